// ### rtl/cpu_branch_skip_bit_exec.sv
// Sequencer for branch, skip, compare, bit and shift instructions
`timescale 1ns/10ps
module cpu_branch_skip_bit_exec #(
  parameter int STACK_DEPTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] pm_addr,
  input wire logic [15:0] pm_data,
  output logic [4:0] io_addr,
  input wire logic [7:0] io_rdata,
  output logic [7:0] io_wdata,
  output logic [7:0] io_wmask,
  output logic io_we
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  exec_pkg::state_e state_ff;
  exec_pkg::state_e nxt_state;
  logic [15:0] ir_ff;
  logic [15:0] pc_ff;
  logic [15:0] nxt_pc;
  logic [1:0] wait_ff;
  logic [1:0] nxt_wait;
  logic [7:0] flags_ff;
  logic [7:0] nxt_flags;
  logic [7:0] gpr_ff [32];
  logic [15:0] stack_ff [STACK_DEPTH];
  logic [SP_W-1:0] sp_ff;
  logic run_ff;
  logic unknown_ff;
  logic [4:0] acc_idx_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [4:0] io_addr_ff;
  logic [7:0] io_wdata_ff;
  logic [7:0] io_wmask_ff;
  logic io_we_ff;
  logic fetch;

  // A following instruction is two words long when its major code says so
  function automatic logic two_word(input logic [15:0] w);
    two_word = (w[exec_pkg::MAJ_LO +: 4] == exec_pkg::MAJ_LONG);
  endfunction : two_word

  // Map a single-register sub code onto a datapath op
  function automatic exec_pkg::alu_op_e single_op(input logic [3:0] s);
    case (s)
      exec_pkg::SGL_TEST: single_op = exec_pkg::alu_test;
      exec_pkg::SGL_CLR: single_op = exec_pkg::alu_clr;
      exec_pkg::SGL_DEC: single_op = exec_pkg::alu_dec;
      exec_pkg::SGL_LSL: single_op = exec_pkg::alu_lsl;
      exec_pkg::SGL_LSR: single_op = exec_pkg::alu_lsr;
      exec_pkg::SGL_ROL: single_op = exec_pkg::alu_rol;
      default: single_op = exec_pkg::alu_none;
    endcase
  endfunction : single_op

  // Instruction fields
  wire [3:0] maj = ir_ff[exec_pkg::MAJ_LO +: 4];
  wire [4:0] src_r = ir_ff[exec_pkg::F_SRC_LO +: 5];
  wire [4:0] rd_pair = ir_ff[exec_pkg::F_RD_LO +: 5];
  wire [1:0] pair_sub = ir_ff[exec_pkg::F_SUB2_LO +: 2];
  wire [4:0] rd_imm = {exec_pkg::IMM_D_BASE,
                       ir_ff[exec_pkg::F_IMM_D_LO +: 4]};
  wire [7:0] k8 = ir_ff[exec_pkg::F_K8_LO +: 8];
  wire [3:0] sgl_sub = ir_ff[exec_pkg::F_SUB4_LO +: 4];
  wire [3:0] flow_sub = ir_ff[exec_pkg::F_FLOW_LO +: 4];
  wire [11:0] k12 = ir_ff[exec_pkg::F_K12_LO +: 12];
  wire [6:0] k7 = ir_ff[exec_pkg::F_K7_LO +: 7];
  wire [2:0] flag_sel = ir_ff[exec_pkg::F_FLAG_LO +: 3];
  wire br_clear = ir_ff[exec_pkg::F_BR_CLEAR];
  wire set_form = ir_ff[exec_pkg::F_SET_FORM];
  wire [4:0] skip_r = ir_ff[exec_pkg::F_SKIP_R_LO +: 5];
  wire [2:0] bit_no = ir_ff[exec_pkg::F_BIT_LO +: 3];

  // Class decode, only meaningful in the first execute cycle
  wire in_exec = (state_ff == exec_pkg::st_exec);
  wire is_pair = in_exec & (maj == exec_pkg::MAJ_PAIR);
  wire is_cp = is_pair & (pair_sub == exec_pkg::PAIR_CP);
  wire is_cmp_c = is_pair & (pair_sub == exec_pkg::PAIR_CMP_C);
  wire is_eq_skip = is_pair & (pair_sub == exec_pkg::PAIR_EQ_SKIP);
  wire is_cmp_imm = in_exec & (maj == exec_pkg::MAJ_CMP_IMM);
  wire is_single = in_exec & (maj == exec_pkg::MAJ_SINGLE);
  wire is_flow = in_exec & (maj == exec_pkg::MAJ_FLOW);
  wire is_ptr_jump = is_flow & (flow_sub == exec_pkg::FLOW_PTR_JUMP);
  wire is_ptr_call = is_flow & (flow_sub == exec_pkg::FLOW_PTR_CALL);
  wire is_sub_exit = is_flow & (flow_sub == exec_pkg::FLOW_SUB_EXIT);
  wire is_irq_exit = is_flow & (flow_sub == exec_pkg::FLOW_IRQ_EXIT);
  wire is_nop = is_flow & (flow_sub == exec_pkg::FLOW_NOP);
  wire is_ofs_jump = in_exec & (maj == exec_pkg::MAJ_OFS_JUMP);
  wire is_ofs_call = in_exec & (maj == exec_pkg::MAJ_OFS_CALL);
  wire is_branch = in_exec & (maj == exec_pkg::MAJ_BRANCH);
  wire is_reg_skip = in_exec & (maj == exec_pkg::MAJ_REG_SKIP);
  wire is_io_skip = in_exec & (maj == exec_pkg::MAJ_IO_SKIP);
  wire is_io_bit = in_exec & (maj == exec_pkg::MAJ_IO_BIT);
  wire is_long = in_exec & (maj == exec_pkg::MAJ_LONG);
  wire is_return = is_sub_exit | is_irq_exit;
  wire is_call = is_ptr_call | is_ofs_call;
  wire is_known_single = (single_op(sgl_sub) != exec_pkg::alu_none);
  wire is_unknown = in_exec & ~(is_pair & (pair_sub != 2'h3))
                  & ~is_cmp_imm & ~(is_single & is_known_single)
                  & ~is_ptr_jump & ~is_ptr_call & ~is_return & ~is_nop
                  & ~is_ofs_jump & ~is_ofs_call & ~is_branch
                  & ~is_reg_skip & ~is_io_skip & ~is_io_bit & ~is_long;

  // Datapath hookup
  alu_if alu_bus ();
  wire [4:0] dst = is_cmp_imm ? rd_imm : (is_single ? src_r : rd_pair);
  assign alu_bus.op = is_cp ? exec_pkg::alu_cp :
                      is_cmp_c ? exec_pkg::alu_cmp_c :
                      is_cmp_imm ? exec_pkg::alu_cp :
                      is_single ? single_op(sgl_sub) :
                      exec_pkg::alu_none;
  assign alu_bus.a = gpr_ff[dst];
  assign alu_bus.b = is_cmp_imm ? k8 : gpr_ff[src_r];
  assign alu_bus.flags_in = flags_ff;

  flag_alu u_alu (
    .bus (alu_bus.alu)
  );

  // Flag selection; the sign-test index is evaluated live as N xor V
  wire signed_lt = flags_ff[exec_pkg::FLG_N] ^ flags_ff[exec_pkg::FLG_V];
  wire flag_val = (flag_sel == 3'(exec_pkg::FLG_S)) ? signed_lt
                : flags_ff[flag_sel];
  // Set form branches on 1, clear form on 0; V and I take the same path
  wire br_taken = is_branch
                & (flag_val != br_clear);

  // Skip conditions; the next instruction is already on pm_data
  wire regs_equal = (gpr_ff[rd_pair] == gpr_ff[src_r]);
  wire reg_bit = gpr_ff[skip_r][bit_no];
  wire io_bit = io_rdata[bit_no];
  wire skip_hit = (is_eq_skip & regs_equal)
                | (is_reg_skip & (reg_bit == set_form))
                | (is_io_skip & (io_bit == set_form));
  wire next_long = two_word(pm_data);

  // Targets; pc_ff already holds the address after this instruction
  wire [15:0] zptr = {gpr_ff[exec_pkg::ZH_IDX], gpr_ff[exec_pkg::ZL_IDX]};
  wire [15:0] rel7 = pc_ff + {{9{k7[6]}}, k7};
  wire [15:0] rel12 = pc_ff + {{4{k12[11]}}, k12};
  wire [SP_W-1:0] sp_dec = sp_ff - SP_W'(1);
  wire [15:0] pop_addr = stack_ff[sp_dec];
  wire redir = is_ptr_jump | is_ptr_call | is_ofs_jump | is_ofs_call
             | is_return | br_taken | skip_hit | is_long | is_io_bit;
  wire [15:0] redir_pc =
    (is_ptr_jump | is_ptr_call) ? zptr :
    (is_ofs_jump | is_ofs_call) ? rel12 :
    is_return ? pop_addr :
    br_taken ? rel7 :
    skip_hit ? (next_long ? pc_ff + 16'h0002 : pc_ff + 16'h0001) :
    is_long ? pc_ff + 16'h0001 : pc_ff;
  // Extra cycles after the first one
  wire [1:0] redir_wait =
    is_ptr_jump ? 2'(exec_pkg::CYC_PTR_JUMP - 1) :
    is_ptr_call ? 2'(exec_pkg::CYC_PTR_CALL - 1) :
    is_ofs_jump ? 2'(exec_pkg::CYC_OFS_JUMP - 1) :
    is_ofs_call ? 2'(exec_pkg::CYC_OFS_CALL - 1) :
    is_return ? 2'(exec_pkg::CYC_RETURN - 1) :
    br_taken ? 2'(exec_pkg::CYC_BR_TAKEN - 1) :
    (skip_hit & next_long) ? 2'(exec_pkg::CYC_SKIP_TWO - 1) :
    skip_hit ? 2'(exec_pkg::CYC_SKIP_ONE - 1) :
    is_io_bit ? 2'(exec_pkg::CYC_IO_BIT - 1) :
    2'(exec_pkg::CYC_LONG - 1);

  // Sequencer: stops only at an instruction boundary, never mid-way
  always_comb begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_wait = wait_ff;
    fetch = 1'b0;
    case (state_ff)
      exec_pkg::st_idle: begin
        if (run_ff) begin
          nxt_state = exec_pkg::st_fetch;
        end
      end
      exec_pkg::st_fetch: begin
        fetch = 1'b1;
      end
      exec_pkg::st_exec: begin
        if (redir) begin
          nxt_pc = redir_pc;
          nxt_wait = redir_wait;
          nxt_state = exec_pkg::st_wait;
        end else if (run_ff) begin
          fetch = 1'b1;
        end else begin
          nxt_state = exec_pkg::st_idle;
        end
      end
      default: begin
        if (wait_ff != 2'h1) begin
          nxt_wait = wait_ff - 2'h1;
        end else if (run_ff) begin
          fetch = 1'b1;
        end else begin
          nxt_state = exec_pkg::st_idle;
        end
      end
    endcase
    if (fetch) begin
      nxt_state = exec_pkg::st_exec;
      nxt_pc = pc_ff + 16'h0001;
    end
  end

  // Flag update: only the flags in the op's mask move, and interrupt exit also sets I
  always_comb begin
    nxt_flags = flags_ff;
    if (in_exec) begin
      nxt_flags = (flags_ff & ~alu_bus.flag_mask)
                | (alu_bus.flags_out & alu_bus.flag_mask);
    end
    if (is_irq_exit) begin
      nxt_flags[exec_pkg::FLG_I] = 1'b1;
    end
  end

  // APB decode; one access cycle, no wait states
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready_ff & pwrite;
  wire hit_ctrl = (paddr == exec_pkg::OFS_CTRL);
  wire hit_status = (paddr == exec_pkg::OFS_STATUS);
  wire hit_pc = (paddr == exec_pkg::OFS_PC);
  wire hit_flags = (paddr == exec_pkg::OFS_FLAGS);
  wire hit_regacc = (paddr == exec_pkg::OFS_REGACC);
  wire addr_ok = hit_ctrl | hit_status | hit_pc | hit_flags | hit_regacc;
  wire idle = (state_ff == exec_pkg::st_idle);
  // Core state is loaded by software only while stopped
  wire pc_load = apb_wr & hit_pc & idle;
  wire flags_load = apb_wr & hit_flags & idle;
  wire reg_load = apb_wr & hit_regacc & idle & pwdata[exec_pkg::REGACC_WE];
  wire unknown_clr = apb_wr & hit_status & pwdata[exec_pkg::ST_UNKNOWN];
  wire [7:0] sp_word = 8'(sp_ff);
  wire [31:0] rd_word =
    hit_ctrl ? {31'h0, run_ff} :
    hit_status ? {16'h0, sp_word, 6'h0, unknown_ff, ~idle} :
    hit_pc ? {16'h0, pc_ff} :
    hit_flags ? {24'h0, flags_ff} :
    hit_regacc ? {19'h0, acc_idx_ff, gpr_ff[acc_idx_ff]} : 32'h0;

  // Bus answer is prepared in the setup cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= (apb_setup & ~pwrite) ? rd_word : 32'h0;
      pready_ff <= apb_setup;
      pslverr_ff <= apb_setup & ~addr_ok;
    end
  end

  // Software-owned control and status; a new event beats the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_ff <= exec_pkg::RST_RUN;
      unknown_ff <= 1'b0;
      acc_idx_ff <= 5'h00;
    end else begin
      if (apb_wr & hit_ctrl) begin
        run_ff <= pwdata[exec_pkg::CTRL_RUN];
      end
      if (apb_wr & hit_regacc) begin
        acc_idx_ff <= pwdata[exec_pkg::REGACC_IDX_LO +: 5];
      end
      unknown_ff <= is_unknown | (unknown_ff & ~unknown_clr);
    end
  end

  // Sequencer state, program counter and flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= exec_pkg::st_idle;
      pc_ff <= exec_pkg::RST_PC;
      wait_ff <= 2'h0;
      ir_ff <= 16'h0000;
      flags_ff <= exec_pkg::RST_FLAGS;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= pc_load ? pwdata[15:0] : nxt_pc;
      wait_ff <= nxt_wait;
      flags_ff <= flags_load ? pwdata[7:0] : nxt_flags;
      if (fetch) begin
        ir_ff <= pm_data;
      end
    end
  end

  // General registers; only software or the datapath write them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) begin
        gpr_ff[i] <= 8'h00;
      end
    end else if (reg_load) begin
      gpr_ff[pwdata[exec_pkg::REGACC_IDX_LO +: 5]] <= pwdata[7:0];
    end else if (in_exec & alu_bus.wr_result) begin
      gpr_ff[dst] <= alu_bus.result;
    end
  end

  // Return stack; it wraps silently, overflow is not detected
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sp_ff <= '0;
    end else if (is_call) begin
      stack_ff[sp_ff] <= pc_ff;
      sp_ff <= sp_ff + SP_W'(1);
    end else if (is_return) begin
      sp_ff <= sp_dec;
    end
  end

  // I/O address follows each fetch so the bit is ready at execute
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_addr_ff <= 5'h00;
      io_wdata_ff <= 8'h00;
      io_wmask_ff <= 8'h00;
      io_we_ff <= 1'b0;
    end else begin
      if (fetch) begin
        io_addr_ff <= pm_data[exec_pkg::F_IO_LO +: 5];
      end
      // Masked write touches one bit, so W1C neighbours stay safe
      io_we_ff <= is_io_bit;
      io_wmask_ff <= is_io_bit ? (8'h01 << bit_no) : 8'h00;
      io_wdata_ff <= (is_io_bit & set_form) ? 8'hFF : 8'h00;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pm_addr = pc_ff;
  assign io_addr = io_addr_ff;
  assign io_wdata = io_wdata_ff;
  assign io_wmask = io_wmask_ff;
  assign io_we = io_we_ff;
endmodule : cpu_branch_skip_bit_exec

// ### shared/exec_pkg.sv
// Constants, encodings and types for the branch, skip and bit execute block
package exec_pkg;
  // Instruction major code, bits 15:12
  localparam int MAJ_LO = 12;
  localparam logic [3:0] MAJ_PAIR = 4'h0;
  localparam logic [3:0] MAJ_CMP_IMM = 4'h1;
  localparam logic [3:0] MAJ_SINGLE = 4'h2;
  localparam logic [3:0] MAJ_FLOW = 4'h3;
  localparam logic [3:0] MAJ_OFS_JUMP = 4'h4;
  localparam logic [3:0] MAJ_OFS_CALL = 4'h5;
  localparam logic [3:0] MAJ_BRANCH = 4'h6;
  localparam logic [3:0] MAJ_REG_SKIP = 4'h7;
  localparam logic [3:0] MAJ_IO_SKIP = 4'h8;
  localparam logic [3:0] MAJ_IO_BIT = 4'h9;
  localparam logic [3:0] MAJ_LONG = 4'hF;
  // Field positions
  localparam int F_SRC_LO = 0;
  localparam int F_RD_LO = 5;
  localparam int F_SUB2_LO = 10;
  localparam int F_IMM_D_LO = 8;
  localparam int F_K8_LO = 0;
  localparam int F_SUB4_LO = 8;
  localparam int F_FLOW_LO = 0;
  localparam int F_K12_LO = 0;
  localparam int F_BR_CLEAR = 10;
  localparam int F_K7_LO = 3;
  localparam int F_FLAG_LO = 0;
  localparam int F_SET_FORM = 9;
  localparam int F_SKIP_R_LO = 4;
  localparam int F_BIT_LO = 0;
  localparam int F_IO_LO = 3;
  // Sub codes
  localparam logic [1:0] PAIR_CP = 2'h0;
  localparam logic [1:0] PAIR_CMP_C = 2'h1;
  localparam logic [1:0] PAIR_EQ_SKIP = 2'h2;
  localparam logic [3:0] SGL_TEST = 4'h0;
  localparam logic [3:0] SGL_CLR = 4'h1;
  localparam logic [3:0] SGL_DEC = 4'h2;
  localparam logic [3:0] SGL_LSL = 4'h3;
  localparam logic [3:0] SGL_LSR = 4'h4;
  localparam logic [3:0] SGL_ROL = 4'h5;
  localparam logic [3:0] FLOW_PTR_JUMP = 4'h0;
  localparam logic [3:0] FLOW_PTR_CALL = 4'h1;
  localparam logic [3:0] FLOW_SUB_EXIT = 4'h2;
  localparam logic [3:0] FLOW_IRQ_EXIT = 4'h3;
  localparam logic [3:0] FLOW_NOP = 4'h4;
  localparam logic [4:0] ZL_IDX = 5'h1E;
  localparam logic [4:0] ZH_IDX = 5'h1F;
  localparam logic IMM_D_BASE = 1'b1;
  // Flag bit positions in the processor flag register
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  localparam logic [7:0] MASK_ZNV = 8'h0E;
  localparam logic [7:0] MASK_ZNVCH = 8'h2F;
  localparam logic [7:0] MASK_ZCNV = 8'h0F;
  // Cycle counts
  localparam int CYC_PTR_JUMP = 2;
  localparam int CYC_PTR_CALL = 3;
  localparam int CYC_OFS_JUMP = 2;
  localparam int CYC_OFS_CALL = 3;
  localparam int CYC_RETURN = 4;
  localparam int CYC_BR_TAKEN = 2;
  localparam int CYC_SKIP_ONE = 2;
  localparam int CYC_SKIP_TWO = 3;
  localparam int CYC_IO_BIT = 2;
  localparam int CYC_LONG = 2;
  // APB map and fields
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_REGACC = 8'h10;
  localparam int CTRL_RUN = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_UNKNOWN = 1;
  localparam int ST_SP_LO = 8;
  localparam int REGACC_IDX_LO = 8;
  localparam int REGACC_WE = 16;
  // Reset values
  localparam logic RST_RUN = 1'b0;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [15:0] RST_PC = 16'h0000;

  typedef enum logic [1:0] {st_idle, st_fetch, st_exec, st_wait} state_e;
  typedef enum logic [3:0] {
    alu_none, alu_test, alu_clr, alu_dec, alu_cp, alu_cmp_c,
    alu_lsl, alu_lsr, alu_rol
  } alu_op_e;
endpackage : exec_pkg

// ### shared/alu_if.sv
// Interface between the sequencer and the flag-producing datapath
`timescale 1ns/10ps
interface alu_if;
  exec_pkg::alu_op_e op;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] flags_in;
  logic [7:0] result;
  logic [7:0] flags_out;
  logic [7:0] flag_mask;
  logic wr_result;
  modport core (
    output op, a, b, flags_in,
    input result, flags_out, flag_mask, wr_result
  );
  modport alu (
    input op, a, b, flags_in,
    output result, flags_out, flag_mask, wr_result
  );
endinterface : alu_if

// ### rtl/flag_alu.sv
// Result and flag datapath for test, compare, decrement and shift ops
`timescale 1ns/10ps
module flag_alu (
  alu_if.alu bus
);
  logic [8:0] diff;
  logic [7:0] r;
  logic c_new;
  logic v_new;
  logic h_new;
  logic z_new;
  logic cin;

  assign cin = bus.flags_in[exec_pkg::FLG_C];

  // Per-op result and raw flags; masks say which flags really change
  always_comb begin
    diff = 9'h000;
    r = 8'h00;
    c_new = 1'b0;
    v_new = 1'b0;
    h_new = 1'b0;
    bus.flag_mask = 8'h00;
    bus.wr_result = 1'b0;
    case (bus.op)
      exec_pkg::alu_test: begin
        r = bus.a & bus.a;
        bus.flag_mask = exec_pkg::MASK_ZNV;
      end
      exec_pkg::alu_clr: begin
        r = bus.a ^ bus.a;
        bus.flag_mask = exec_pkg::MASK_ZNV;
        bus.wr_result = 1'b1;
      end
      exec_pkg::alu_dec: begin
        r = bus.a - 8'h01;
        v_new = (bus.a == 8'h80);
        bus.flag_mask = exec_pkg::MASK_ZNV;
        bus.wr_result = 1'b1;
      end
      exec_pkg::alu_cp, exec_pkg::alu_cmp_c: begin
        // Carry enters only for the with-carry form
        diff = {1'b0, bus.a} - {1'b0, bus.b}
             - {8'h00, (bus.op == exec_pkg::alu_cmp_c) & cin};
        r = diff[7:0];
        c_new = (~bus.a[7] & bus.b[7]) | (bus.b[7] & r[7])
              | (r[7] & ~bus.a[7]);
        h_new = (~bus.a[3] & bus.b[3]) | (bus.b[3] & r[3])
              | (r[3] & ~bus.a[3]);
        v_new = (bus.a[7] & ~bus.b[7] & ~r[7])
              | (~bus.a[7] & bus.b[7] & r[7]);
        bus.flag_mask = exec_pkg::MASK_ZNVCH;
      end
      exec_pkg::alu_lsl, exec_pkg::alu_rol: begin
        r = {bus.a[6:0], (bus.op == exec_pkg::alu_rol) & cin};
        c_new = bus.a[7];
        v_new = r[7] ^ bus.a[7];
        bus.flag_mask = exec_pkg::MASK_ZCNV;
        bus.wr_result = 1'b1;
      end
      exec_pkg::alu_lsr: begin
        r = {1'b0, bus.a[7:1]};
        c_new = bus.a[0];
        v_new = bus.a[0];
        bus.flag_mask = exec_pkg::MASK_ZCNV;
        bus.wr_result = 1'b1;
      end
      default: begin
        r = 8'h00;
      end
    endcase
  end

  // With-carry compare keeps zero only if it was already set
  assign z_new = (r == 8'h00)
               & ((bus.op != exec_pkg::alu_cmp_c)
                  | bus.flags_in[exec_pkg::FLG_Z]);
  assign bus.result = r;
  assign bus.flags_out = {bus.flags_in[7:6], h_new, bus.flags_in[4],
                          v_new, r[7], z_new, c_new};
endmodule : flag_alu

// ### verif/exec_asserts.sv
// Port checks for the branch, skip and bit execute block
`timescale 1ns/10ps
module exec_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic [4:0] io_addr,
  input wire logic [7:0] io_wmask,
  input wire logic io_we
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Setup then access phase of one bus transfer
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable && pready; endsequence
  ready_after_setup_a: assert property (setup_s |=> access_s)
    else $error("no answer after setup");
  ready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("answer without setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error outside access");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  io_pulse_a: assert property (io_we |=> !io_we)
    else $error("io write longer than one cycle");
  io_one_bit_a: assert property (io_we |-> $onehot(io_wmask))
    else $error("io write touches other bits");
  io_addr_hold_a: assert property (io_we |-> $stable(io_addr))
    else $error("io address moved during write");
endmodule : exec_asserts

bind cpu_branch_skip_bit_exec exec_asserts exec_asserts_inst (.clk(clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .io_addr(io_addr),
  .io_wmask(io_wmask), .io_we(io_we));

// ### verif/pm_io_model.sv
// Program memory and I/O register space beside the core
`timescale 1ns/10ps
module pm_io_model (
  input wire logic clk,
  input wire logic [15:0] pm_addr,
  output logic [15:0] pm_data,
  input wire logic [4:0] io_addr,
  output logic [7:0] io_rdata,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_wmask,
  input wire logic io_we
);
  logic [15:0] mem [0:63];
  logic [7:0] io [0:31];
  // Reads are combinational; small memory aliases high addresses
  assign pm_data = mem[pm_addr[5:0]];
  assign io_rdata = io[io_addr];
  // Only masked bits change, so write-one-to-clear flags stay intact
  always @(posedge clk) begin
    if (io_we === 1'b1) begin
      io[io_addr] <= (io[io_addr] & ~io_wmask) | (io_wdata & io_wmask);
    end
  end
endmodule : pm_io_model

// ### verif/tb.sv
// Self-checking bench for the branch, skip and bit execute block
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, io_we;
  logic [15:0] pm_addr, pm_data;
  logic [4:0] io_addr;
  logic [7:0] io_rdata, io_wdata, io_wmask;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  cpu_branch_skip_bit_exec cpu_branch_skip_bit_exec_inst (.clk(clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pm_addr(pm_addr), .pm_data(pm_data),
    .io_addr(io_addr), .io_rdata(io_rdata), .io_wdata(io_wdata),
    .io_wmask(io_wmask), .io_we(io_we));
  pm_io_model pm_io_model_inst (.clk(clk), .pm_addr(pm_addr),
    .pm_data(pm_data), .io_addr(io_addr), .io_rdata(io_rdata),
    .io_wdata(io_wdata), .io_wmask(io_wmask), .io_we(io_we));
  initial forever #50 clk = ~clk;
  task finish_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Run from word 0 into a self loop, stop, then read the PC
  task run_prog;
    apb(1'b1, exec_pkg::OFS_PC, 32'h0);
    apb(1'b1, exec_pkg::OFS_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    apb(1'b1, exec_pkg::OFS_CTRL, 32'h0);
    do apb(1'b0, exec_pkg::OFS_STATUS, 32'h0); while (rd[0] === 1'b1);
    apb(1'b0, exec_pkg::OFS_PC, 32'h0);
  endtask : run_prog
  task reg_op(input logic [4:0] i, input logic w, input logic [7:0] v);
    apb(1'b1, exec_pkg::OFS_REGACC, {15'h0, w, 3'h0, i, v});
    apb(1'b0, exec_pkg::OFS_REGACC, 32'h0);
  endtask : reg_op
  task one_op(input logic [15:0] ins, input logic [7:0] ef);
    pm_io_model_inst.mem[0] = ins;
    pm_io_model_inst.mem[1] = 16'h4FFF;
    run_prog;
    chk("pc", 32'h1, rd);
    apb(1'b0, exec_pkg::OFS_FLAGS, 32'h0);
    chk("flags", {24'h0, ef}, rd);
  endtask : one_op
  task t_reset;
    apb(1'b0, exec_pkg::OFS_FLAGS, 32'h0);
    chk("flags", 32'h0, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
  endtask : t_reset
  // Compare keeps r1; shift, then zeroing leaves carry alone
  task t_alu;
    reg_op(5'd1, 1'b1, 8'h10);
    reg_op(5'd2, 1'b1, 8'h20);
    reg_op(5'd3, 1'b1, 8'h81);
    reg_op(5'd4, 1'b1, 8'h55);
    one_op(16'h0022, 8'h05);
    reg_op(5'd1, 1'b0, 8'h00);
    chk("r1", 32'h10, {24'h0, rd[7:0]});
    one_op(16'h2303, 8'h09);
    reg_op(5'd3, 1'b0, 8'h00);
    chk("r3", 32'h02, {24'h0, rd[7:0]});
    one_op(16'h2104, 8'h03);
  endtask : t_alu
  // Each flag, both forms; index 4 tests N xor V, which stays zero
  task t_branch;
    for (int s = 0; s < 8; s++) begin
      for (int c = 0; c < 2; c++) begin
        apb(1'b1, exec_pkg::OFS_FLAGS, 32'h1 << s);
        for (int k = 1; k < 4; k++) pm_io_model_inst.mem[k] = 16'h4FFF;
        pm_io_model_inst.mem[0] = 16'(16'h6010 | (c << 10) | s);
        run_prog;
        chk("branch pc", ((s == 4) ? c : !c) ? 3 : 1, rd);
        apb(1'b0, exec_pkg::OFS_FLAGS, 32'h0);
        chk("branch flags", 32'h1 << s, rd);
      end
    end
  endtask : t_branch
  task t_io;
    pm_io_model_inst.io[3] = 8'h04;
    pm_io_model_inst.io[5] = 8'h80;
    pm_io_model_inst.mem[0] = 16'h821A;
    pm_io_model_inst.mem[2] = 16'h9229;
    run_prog;
    chk("skip pc", 32'h3, rd);
    chk("io bit", 32'h82, {24'h0, pm_io_model_inst.io[5]});
  endtask : t_io
  task pm(input int a, input logic [15:0] w);
    pm_io_model_inst.mem[a] = w;
  endtask : pm
  // Pointer call, interrupt exit, equal skip over two words, bit skip
  task t_flow;
    reg_op(5'd30, 1'b1, 8'h08);
    reg_op(5'd5, 1'b1, 8'h33);
    reg_op(5'd6, 1'b1, 8'h33);
    apb(1'b1, exec_pkg::OFS_FLAGS, 32'h0);
    pm(0, 16'h3001);
    pm(1, 16'h08A6);
    pm(2, 16'hF000);
    pm(3, 16'h4FFF);
    pm(4, 16'h7250);
    pm(5, 16'h4FFF);
    pm(6, 16'h1001);
    pm(7, 16'h4FFF);
    pm(8, 16'h3003);
    run_prog;
    chk("flow pc", 32'h7, rd);
    apb(1'b0, exec_pkg::OFS_FLAGS, 32'h0);
    chk("flow flags", 32'hA5, rd);
    apb(1'b0, exec_pkg::OFS_STATUS, 32'h0);
    chk("stack level", 32'h0, {24'h0, rd[15:8]});
  endtask : t_flow
  // Decrement, rotate through carry, unknown code, call, jump, exit
  task t_misc;
    reg_op(5'd7, 1'b1, 8'h80);
    reg_op(5'd9, 1'b1, 8'h40);
    reg_op(5'd30, 1'b1, 8'h0A);
    apb(1'b1, exec_pkg::OFS_FLAGS, 32'h1);
    pm(0, 16'h2207);
    pm(1, 16'h2509);
    pm(2, 16'hA000);
    pm(3, 16'h5002);
    pm(4, 16'h4FFF);
    pm(6, 16'h3000);
    pm(10, 16'h3002);
    run_prog;
    chk("misc pc", 32'h4, rd);
    apb(1'b0, exec_pkg::OFS_FLAGS, 32'h0);
    chk("misc flags", 32'h0C, rd);
    apb(1'b0, exec_pkg::OFS_STATUS, 32'h0);
    chk("status", 32'h2, rd);
    apb(1'b1, exec_pkg::OFS_STATUS, 32'h2);
    apb(1'b0, exec_pkg::OFS_STATUS, 32'h0);
    chk("status clr", 32'h0, rd);
    reg_op(5'd9, 1'b0, 8'h00);
    chk("r9", 32'h81, {24'h0, rd[7:0]});
    reg_op(5'd7, 1'b0, 8'h00);
    chk("r7", 32'h7F, {24'h0, rd[7:0]});
  endtask : t_misc
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_alu;
    t_branch;
    t_io;
    t_flow;
    t_misc;
    finish_test;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      finish_test;
    end
  end
endmodule : tb
